// ==== rtl/vrts_ctrl.sv ====
/*
 * control register of the fixed reference and temperature sensor,
 * reached as an apb slave, with the settling timer behind the ready flag.
 * assumes: apb master on pclk; analog side takes the decoded controls.
 */
// Register access over APB was left to the implementer.
// What this block does
// - bit 7 enables fixed reference, resets 0
// - bit 6 read-only ready flag
// - ready set only after settling time
// - bit 5 enables temperature sensor
// - bit 4 selects sensor high/low range
// - bits 3:2 second buffer gain, reset off
// - bits 1:0 first buffer gain, reset off
// - second buffer feeds dac, comparators, channel
// - first buffer feeds converter reference, channel
// - one register holds all controls
`include "vrts_defines.svh"

module vrts_ctrl (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic reference_enable,
	output logic reference_ready,
	output logic sensor_enable,
	output logic sensor_range_select,
	output logic [1:0] second_buffer_gain,
	output logic [1:0] first_buffer_gain,
	output logic [1:0] dac_cmp_reference_gain,
	output logic [1:0] converter_channel2_gain,
	output logic [1:0] converter_reference_gain,
	output logic [1:0] converter_channel1_gain
);

	localparam int SETTLE_CYCLES = `VRTS_SETTLE_CYCLES;
	localparam logic [15:0] SETTLE_LAST = 16'(SETTLE_CYCLES - 1);

	logic [7:0] ctrl_q;
	logic [15:0] settle_cnt_q;
	logic [31:0] prdata_q;
	vrts_pkg::vrts_state_t state_q;
	logic hit;
	logic wr_en;
	logic rd_en;

	// single word, one cycle access phase
	assign hit = (paddr[11:2] == `VRTS_CTRL_ADDR >> 2);
	assign wr_en = psel && penable && pwrite && hit && pstrb[0];
	assign rd_en = psel && !penable && !pwrite;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !hit;
	assign prdata = prdata_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= `VRTS_CTRL_RESET;
		end else if (wr_en) begin
			// ready position is never stored from the bus
			ctrl_q <= pwdata[7:0] & ~(8'h01 << `VRTS_RDY_BIT);
		end
	end

	// read data captured in setup so it is stable through access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0000_0000;
		end else if (rd_en) begin
			prdata_q <= 32'h0000_0000;
			if (hit) begin
				prdata_q[7:0] <= ctrl_q;
				prdata_q[`VRTS_RDY_BIT] <= reference_ready;
			end
		end
	end

	// settling: fixed cycle count stands in for analog settling
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= vrts_pkg::VRTS_ST_OFF;
			settle_cnt_q <= 16'h0000;
		end else begin
			case (state_q)
				vrts_pkg::VRTS_ST_OFF: begin
					settle_cnt_q <= 16'h0000;
					if (ctrl_q[`VRTS_EN_BIT]) begin
						state_q <= vrts_pkg::VRTS_ST_SETTLE;
					end
				end
				vrts_pkg::VRTS_ST_SETTLE: begin
					if (!ctrl_q[`VRTS_EN_BIT]) begin
						state_q <= vrts_pkg::VRTS_ST_OFF;
					end else if (settle_cnt_q == SETTLE_LAST) begin
						state_q <= vrts_pkg::VRTS_ST_READY;
					end else begin
						settle_cnt_q <= settle_cnt_q + 16'h0001;
					end
				end
				vrts_pkg::VRTS_ST_READY: begin
					if (!ctrl_q[`VRTS_EN_BIT]) begin
						state_q <= vrts_pkg::VRTS_ST_OFF;
					end
				end
				default: state_q <= vrts_pkg::VRTS_ST_OFF;
			endcase
		end
	end

	// gated by enable too, so a disable write drops ready the same edge
	assign reference_ready = (state_q == vrts_pkg::VRTS_ST_READY)
		&& ctrl_q[`VRTS_EN_BIT];
	assign reference_enable = ctrl_q[`VRTS_EN_BIT];
	assign sensor_enable = ctrl_q[`VRTS_SENSOR_ENABLE_BIT];
	assign sensor_range_select = ctrl_q[`VRTS_SENSOR_RANGE_SELECT_BIT];
	assign second_buffer_gain =
		ctrl_q[`VRTS_BUF2_HI:`VRTS_BUF2_LO];
	assign first_buffer_gain =
		ctrl_q[`VRTS_BUF1_HI:`VRTS_BUF1_LO];
	// second buffer never reaches the converter reference
	assign dac_cmp_reference_gain = second_buffer_gain;
	assign converter_channel2_gain = second_buffer_gain;
	assign converter_reference_gain = first_buffer_gain;
	assign converter_channel1_gain = first_buffer_gain;

endmodule : vrts_ctrl

// ==== rtl/vrts_defines.svh ====
/*
 * offsets, field positions, reset values and timing counts for the
 * reference and temperature control register.
 * assumes: included by bare name from rtl files.
 */
`ifndef VRTS_DEFINES_SVH
`define VRTS_DEFINES_SVH

`define VRTS_CTRL_ADDR 12'hF5C
`define VRTS_CTRL_INDEX 12'h3D7
`define VRTS_EN_BIT 7
`define VRTS_RDY_BIT 6
`define VRTS_SENSOR_ENABLE_BIT 5
`define VRTS_SENSOR_RANGE_SELECT_BIT 4
`define VRTS_BUF2_HI 3
`define VRTS_BUF2_LO 2
`define VRTS_BUF1_HI 1
`define VRTS_BUF1_LO 0
`define VRTS_CTRL_RESET 8'h00
`define VRTS_SETTLE_NS 1000
`define VRTS_CLK_PERIOD_NS 8
`define VRTS_SETTLE_CYCLES \
	((`VRTS_SETTLE_NS + `VRTS_CLK_PERIOD_NS - 1) / `VRTS_CLK_PERIOD_NS)

`endif

// ==== rtl/vrts_pkg.sv ====
/*
 * types for the reference and temperature control block.
 * assumes: nothing beyond a SystemVerilog compiler.
 */
package vrts_pkg;

	typedef enum logic [1:0] {
		VRTS_BUF_OFF,
		VRTS_BUF_X1,
		VRTS_BUF_X2,
		VRTS_BUF_X4
	} vrts_gain_t;

	typedef enum logic [1:0] {
		VRTS_ST_OFF,
		VRTS_ST_SETTLE,
		VRTS_ST_READY
	} vrts_state_t;

endpackage : vrts_pkg

// ==== testbench/testbench.sv ====
/* apb bench for vrts_ctrl, reads checked from a queue.
 assumes: rtl compiled first. */
`include "vrts_defines.svh"
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata;
	logic [3:0] pstrb = 4'hF;
	logic pready, pslverr;
	logic [32:0] exp_q[$];
	logic [7:0] v;
	int fail_count = 0, compares = 0, cyc = 0, i;
	always #4 pclk = ~pclk;
	vrts_ctrl dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .pstrb, .prdata, .pready, .pslverr, .reference_enable(),
		.reference_ready(), .sensor_enable(), .sensor_range_select(),
		.second_buffer_gain(), .first_buffer_gain(),
		.dac_cmp_reference_gain(), .converter_channel2_gain(),
		.converter_reference_gain(), .converter_channel1_gain());
	task automatic apb(input logic w, input logic [11:0] a,
			input logic [31:0] d, input logic [3:0] s);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rd(input logic [11:0] a, input logic [32:0] e);
		exp_q.push_back(e);
		apb(1'b0, a, 32'h0, 4'hF);
	endtask : rd
	task automatic compare_read(input logic [32:0] e, input logic [32:0] g);
		compares++;
		if (g !== e) begin
			fail_count++;
			$display("MISMATCH read exp %h got %h", e, g);
		end
	endtask : compare_read
	task automatic results();
		$display("compares %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : results
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 3000) begin
			fail_count++;
			results();
		end
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			compare_read(exp_q.pop_front(), {pslverr, prdata});
		end
	end
	initial begin
		void'($urandom(94));
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		rd(`VRTS_CTRL_ADDR, 33'h0);
		for (i = 0; i < 4; i++) begin
			v = {2'b01, 2'($urandom), i[1:0], 2'(3 - i)};
			apb(1'b1, `VRTS_CTRL_ADDR, {24'h0, v}, 4'h1);
			rd(`VRTS_CTRL_ADDR, {25'h0, v & 8'hBF});
		end
		$display("test fields done");
		apb(1'b1, `VRTS_CTRL_ADDR, 32'h80, 4'hE);
		apb(1'b1, 12'h004, 32'hFF, 4'hF);
		rd(`VRTS_CTRL_ADDR, {25'h0, v & 8'hBF});
		rd(12'h004, 33'h1_0000_0000);
		// sensor on, high range: software then uses the high-range words
		apb(1'b1, `VRTS_CTRL_ADDR, 32'h31, 4'h1);
		// acquisition wait before any conversion and averaging
		repeat (8) @(posedge pclk);
		rd(`VRTS_CTRL_ADDR, 33'h31);
		apb(1'b1, `VRTS_CTRL_ADDR, 32'h80, 4'h1);
		rd(`VRTS_CTRL_ADDR, 33'h80);
		repeat (140) @(posedge pclk);
		rd(`VRTS_CTRL_ADDR, 33'hC0);
		apb(1'b1, `VRTS_CTRL_ADDR, 32'h0, 4'h1);
		rd(`VRTS_CTRL_ADDR, 33'h0);
		$display("test ready done");
		@(posedge pclk);
		results();
	end
endmodule : testbench

// ==== testbench/vrts_ctrl_properties.sv ====
/* port checker for vrts_ctrl.
 assumes: bound to vrts_ctrl; one clock, async reset. */
`include "vrts_defines.svh"
module vrts_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	input wire logic reference_enable,
	input wire logic reference_ready,
	input wire logic sensor_enable,
	input wire logic sensor_range_select,
	input wire logic [1:0] second_buffer_gain,
	input wire logic [1:0] first_buffer_gain,
	input wire logic [1:0] dac_cmp_reference_gain,
	input wire logic [1:0] converter_reference_gain
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire hit = paddr == `VRTS_CTRL_ADDR;
	wire acc = psel & penable;
	wire wr = acc & pwrite & hit & pstrb[0];
	wire [6:0] ctl = {reference_enable, sensor_enable, sensor_range_select,
		second_buffer_gain, first_buffer_gain};
	wire [6:0] wd = {pwdata[7], pwdata[5:0]};
	chk_ctl_write: assert property (wr |=> ctl == $past(wd))
		else $error("ctl write");
	chk_ctl_hold: assert property (!wr |=> $stable(ctl))
		else $error("ctl hold");
	chk_rdy_off: assert property (!reference_enable |-> !reference_ready)
		else $error("rdy off");
	chk_rdy_settle: assert property ($rose(reference_enable) |->
		!reference_ready [*8]) else $error("rdy early");
	chk_buf2_route: assert property (
		dac_cmp_reference_gain == second_buffer_gain) else $error("buf2");
	chk_buf1_route: assert property (
		converter_reference_gain == first_buffer_gain) else $error("buf1");
	chk_addr_err: assert property (acc |-> pslverr == !hit)
		else $error("slverr");
	chk_read_data: assert property (acc & !pwrite & hit |->
		{prdata[31:8], prdata[7], prdata[5:0]} == {24'h0, ctl})
		else $error("rdata");
endmodule : vrts_chk
bind vrts_ctrl vrts_chk chk_u (.*);
